// >>> design/uiaf_axil.sv
// uiaf_axil: axi4-lite slave front end; yields one-cycle read and write
// strobes with an address, and returns responses.
// assumes one master; one write and one read outstanding at most.
module uiaf_axil (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // write channels
    input wire logic [uiaf_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [uiaf_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register side
    output uiaf_pkg::uiaf_req_s wr_req,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output uiaf_pkg::uiaf_req_s rd_req,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    import uiaf_pkg::*;
    logic aw_have_reg, w_have_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;
    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
    assign wr_fire = aw_have_reg && w_have_reg;
    always_ff @(posedge clk) begin
        if (!rst_n || wr_fire) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
        end
    end
    assign wr_req = '{valid: wr_fire, addr: aw_addr_reg};
    assign wr_data = w_data_reg;
    assign wr_strb = w_strb_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    logic rd_fire;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_req = '{valid: rd_fire, addr: s_axi_araddr};
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // uiaf_axil

// >>> design/uiaf_gate.sv
// uiaf_gate: per-source enable gating onto the combined usb interrupt.
// assumes flags are levels from the usb engine on the same clock.
module uiaf_gate (
    // flags and enables
    input wire uiaf_pkg::uiaf_src_s flags,
    input wire logic [uiaf_pkg::SRC_N-1:0] enables,
    input wire logic host_mode,
    input wire logic bus_reset_flag,
    input wire logic detach_flag,
    // result
    output logic [uiaf_pkg::SRC_N-1:0] gated,
    output logic combined_usb_irq
);
    import uiaf_pkg::*;
    logic [SRC_N-1:0] src;
    always_comb begin
        src = flags;
        // bit 0 source is chosen by role
        src[BIT_RST_DET] = host_mode ? detach_flag : bus_reset_flag;
    end
    genvar i;
    generate
        for (i = 0; i < SRC_N; i++) begin : g_src
            assign gated[i] = src[i] & enables[i];
        end
    endgenerate
    // error reaches the combined irq only through its enable
    assign combined_usb_irq = |gated;
endmodule // uiaf_gate

// >>> design/uiaf_pkg.sv
// uiaf_pkg: register map, field layout and types for the usb interrupt
// enable, device address and frame-low block.
// assumes an axi4-lite register bus with 32-bit data on a 100 MHz clock.
// Contract
// - enable bit 7 gates the stall handshake interrupt.
// - enable bit 6 gates the attach interrupt.
// - enable bit 5 gates the resume interrupt.
// - enable bit 4 gates the bus idle interrupt.
// - enable bit 3 gates the token-done flag interrupt.
// - enable bit 2 gates the start-of-frame flag interrupt.
// - enable bit 1 gates usb error; only then does it reach combined irq.
// - device mode: enable bit 0 gates the bus reset flag.
// - host mode: enable bit 0 gates the detach flag instead.
// - bits 31..8 of the three registers read as zero.
// - address bit 7 selects low speed (1) or full speed for next token.
// - address bits 6..0 hold the read/write 7-bit device address.
// - on each sof token, frame-low takes frame number bits 7..0.
package uiaf_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DEV_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_FRAME_LOW = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_EVT_CLEAR = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_EVT_ENABLE = 8'h14;
    localparam int SRC_N = 8;
    localparam int BIT_STALL = 7;
    localparam int BIT_ATTACH = 6;
    localparam int BIT_RESUME = 5;
    localparam int BIT_IDLE = 4;
    localparam int BIT_TOKEN = 3;
    localparam int BIT_SOF = 2;
    localparam int BIT_ERROR = 1;
    localparam int BIT_RST_DET = 0;
    localparam int FRAME_W = 11;
    localparam int DEVICE_ADDRESS_FIELD_W = 7;
    localparam int EVT_N = 3;
    localparam int EVT_SOF = 0;
    localparam int EVT_ADDR_WR = 1;
    localparam int EVT_IRQ_RISE = 2;
    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic low_speed_token_select;
        logic [DEVICE_ADDRESS_FIELD_W-1:0] device_address_field;
    } uiaf_addr_s;

    typedef struct packed {
        logic stall;
        logic attach;
        logic resume;
        logic bus_idle;
        logic token_done_flag;
        logic frame_start_flag;
        logic usb_error;
        logic reset_or_detach;
    } uiaf_src_s;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } uiaf_req_s;
endpackage

// >>> design/uiaf_top.sv
// uiaf_top: usb interrupt enables, device address and frame-low registers.
// assumes the usb engine supplies flags and the sof frame number on clk.
module uiaf_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // axi4-lite slave
    input wire logic [uiaf_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [uiaf_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // usb engine
    input wire logic host_mode,
    input wire uiaf_pkg::uiaf_src_s usb_flags,
    input wire logic bus_reset_flag,
    input wire logic detach_flag,
    input wire logic sof_received,
    input wire logic [uiaf_pkg::FRAME_W-1:0] frame_number,
    // outputs to the engine and the cpu
    output logic combined_usb_irq,
    output logic low_speed_token_select,
    output logic [uiaf_pkg::DEVICE_ADDRESS_FIELD_W-1:0] device_address_field,
    output logic block_irq
);
    import uiaf_pkg::*;

    function automatic logic hit(input uiaf_req_s r,
                                 input logic [ADDR_W-1:0] off);
        return r.valid && (r.addr == off);
    endfunction

    uiaf_req_s wr_req, rd_req;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] rd_data;
    logic wr_ok, rd_ok;
    logic [7:0] irq_enable_reg;
    uiaf_addr_s addr_reg;
    logic [7:0] frame_low_reg;
    logic [EVT_N-1:0] evt_status_reg, evt_enable_reg, evt_set;
    logic [SRC_N-1:0] gated;
    logic combined_d_reg;

    uiaf_axil u_axil (
        .clk(clk),
        .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_req(wr_req),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_req(rd_req),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    uiaf_gate u_gate (
        .flags(usb_flags),
        .enables(irq_enable_reg),
        .host_mode(host_mode),
        .bus_reset_flag(bus_reset_flag),
        .detach_flag(detach_flag),
        .gated(gated),
        .combined_usb_irq(combined_usb_irq)
    );

    // only byte lane 0 carries implemented bits
    logic wr_lane0;
    assign wr_lane0 = wr_strb[0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_enable_reg <= REG8_RESET;
        end else if (hit(wr_req, OFF_IRQ_ENABLE) && wr_lane0) begin
            irq_enable_reg <= wr_data[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_reg <= REG8_RESET;
        end else if (hit(wr_req, OFF_DEV_ADDR) && wr_lane0) begin
            addr_reg <= wr_data[7:0];
        end
    end
    assign low_speed_token_select = addr_reg.low_speed_token_select;
    assign device_address_field = addr_reg.device_address_field;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_low_reg <= REG8_RESET;
        end else if (sof_received) begin
            frame_low_reg <= frame_number[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            combined_d_reg <= 1'b0;
        end else begin
            combined_d_reg <= combined_usb_irq;
        end
    end

    // block events: sof capture, address write, combined irq rising
    always_comb begin
        evt_set = '0;
        evt_set[EVT_SOF] = sof_received;
        evt_set[EVT_ADDR_WR] = hit(wr_req, OFF_DEV_ADDR) && wr_lane0;
        evt_set[EVT_IRQ_RISE] = combined_usb_irq && !combined_d_reg;
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            evt_status_reg <= '0;
        end else if (hit(wr_req, OFF_EVT_CLEAR) && wr_lane0) begin
            evt_status_reg <= (evt_status_reg & ~wr_data[EVT_N-1:0]) | evt_set;
        end else begin
            evt_status_reg <= evt_status_reg | evt_set;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            evt_enable_reg <= '0;
        end else if (hit(wr_req, OFF_EVT_ENABLE) && wr_lane0) begin
            evt_enable_reg <= wr_data[EVT_N-1:0];
        end
    end
    assign block_irq = |(evt_status_reg & evt_enable_reg);

    always_comb begin
        wr_ok = (wr_req.addr == OFF_IRQ_ENABLE) ||
                (wr_req.addr == OFF_DEV_ADDR) ||
                (wr_req.addr == OFF_FRAME_LOW) ||
                (wr_req.addr == OFF_EVT_CLEAR) ||
                (wr_req.addr == OFF_EVT_ENABLE) ||
                (wr_req.addr == OFF_EVT_STATUS);
    end

    // upper bits read as zero
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (rd_req.addr)
            OFF_IRQ_ENABLE: rd_data[7:0] = irq_enable_reg;
            OFF_DEV_ADDR: rd_data[7:0] = addr_reg;
            OFF_FRAME_LOW: rd_data[7:0] = frame_low_reg;
            OFF_EVT_STATUS: rd_data[EVT_N-1:0] = evt_status_reg;
            OFF_EVT_CLEAR: rd_data = 32'h0000_0000;
            OFF_EVT_ENABLE: rd_data[EVT_N-1:0] = evt_enable_reg;
            default: rd_ok = 1'b0;
        endcase
    end

    // per-source gating onto the combined irq
    a_error_gated: assert property (
        @(posedge clk) disable iff (!rst_n)
        (usb_flags.usb_error && !irq_enable_reg[BIT_ERROR] &&
         (gated & ~(8'h01 << BIT_ERROR)) == '0) |-> !combined_usb_irq)
        else $error("error irq passed while its enable was clear");

    a_error_passes: assert property (
        @(posedge clk) disable iff (!rst_n)
        (usb_flags.usb_error && irq_enable_reg[BIT_ERROR])
        |-> combined_usb_irq)
        else $error("enabled error did not raise combined irq");

    a_stall_passes: assert property (
        @(posedge clk) disable iff (!rst_n)
        (usb_flags.stall && irq_enable_reg[BIT_STALL]) |-> combined_usb_irq)
        else $error("enabled stall did not raise combined irq");

    a_attach_passes: assert property (
        @(posedge clk) disable iff (!rst_n)
        (usb_flags.attach && irq_enable_reg[BIT_ATTACH])
        |-> combined_usb_irq)
        else $error("enabled attach did not raise combined irq");

    a_resume_passes: assert property (
        @(posedge clk) disable iff (!rst_n)
        (usb_flags.resume && irq_enable_reg[BIT_RESUME])
        |-> combined_usb_irq)
        else $error("enabled resume did not raise combined irq");

    a_idle_passes: assert property (
        @(posedge clk) disable iff (!rst_n)
        (usb_flags.bus_idle && irq_enable_reg[BIT_IDLE])
        |-> combined_usb_irq)
        else $error("enabled bus idle did not raise combined irq");

    a_token_passes: assert property (
        @(posedge clk) disable iff (!rst_n)
        (usb_flags.token_done_flag && irq_enable_reg[BIT_TOKEN])
        |-> combined_usb_irq)
        else $error("enabled token done did not raise combined irq");

    a_sof_passes: assert property (
        @(posedge clk) disable iff (!rst_n)
        (usb_flags.frame_start_flag && irq_enable_reg[BIT_SOF])
        |-> combined_usb_irq)
        else $error("enabled start of frame did not raise combined irq");

    a_host_detach: assert property (
        @(posedge clk) disable iff (!rst_n)
        (host_mode && detach_flag && irq_enable_reg[BIT_RST_DET])
        |-> gated[BIT_RST_DET])
        else $error("enabled detach ignored in host mode");

    a_detach_masked: assert property (
        @(posedge clk) disable iff (!rst_n)
        (host_mode && !irq_enable_reg[BIT_RST_DET])
        |-> !gated[BIT_RST_DET])
        else $error("detach passed while its enable was clear");

    a_host_reset_ignored: assert property (
        @(posedge clk) disable iff (!rst_n)
        (host_mode && !detach_flag) |-> !gated[BIT_RST_DET])
        else $error("bus reset reached bit 0 in host mode");

    a_device_reset: assert property (
        @(posedge clk) disable iff (!rst_n)
        !host_mode |-> (gated[BIT_RST_DET] ==
        (bus_reset_flag && irq_enable_reg[BIT_RST_DET])))
        else $error("bus reset gating wrong in device mode");

    a_none_enabled: assert property (
        @(posedge clk) disable iff (!rst_n)
        (irq_enable_reg == 8'h00) |-> !combined_usb_irq)
        else $error("combined irq with no enables");

    // register contents
    a_sof_capture: assert property (
        @(posedge clk) disable iff (!rst_n)
        sof_received |=> frame_low_reg == $past(frame_number[7:0]))
        else $error("frame low not captured on sof");

    a_frame_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !sof_received |=> $stable(frame_low_reg))
        else $error("frame low changed without sof");

    a_addr_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        (hit(wr_req, OFF_DEV_ADDR) && wr_lane0) |=>
        {low_speed_token_select, device_address_field} == $past(wr_data[7:0]))
        else $error("address write not applied");

    a_addr_stable: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(hit(wr_req, OFF_DEV_ADDR) && wr_lane0) |=> $stable(addr_reg))
        else $error("address changed without a write");

    a_enable_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        (hit(wr_req, OFF_IRQ_ENABLE) && wr_lane0) |=>
        irq_enable_reg == $past(wr_data[7:0]))
        else $error("enable write not applied");

    a_enable_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(hit(wr_req, OFF_IRQ_ENABLE) && wr_lane0) |=>
        $stable(irq_enable_reg))
        else $error("enables changed without a write");

    a_upper_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    a_slverr_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        (s_axi_rvalid && s_axi_rresp == RESP_SLVERR) |->
        s_axi_rdata == 32'h0000_0000)
        else $error("refused read returned data");

    a_reset_zero: assert property (
        @(posedge clk)
        !rst_n |=> (irq_enable_reg == 8'h00 && addr_reg == 8'h00 &&
        frame_low_reg == 8'h00))
        else $error("registers not zero after reset");
endmodule // uiaf_top

// >>> verification/testbench.sv
// testbench: register and interrupt gating checks over axi4-lite.
// assumes uiaf_top and the usb model; one clk at 100 MHz.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import uiaf_pkg::*;
    logic clk, rst_n;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    uiaf_src_s usb_flags;
    logic host_mode, bus_reset_flag, detach_flag, sof_received;
    logic [FRAME_W-1:0] frame_number;
    logic combined_usb_irq, low_speed_token_select, block_irq;
    logic [DEVICE_ADDRESS_FIELD_W-1:0] device_address_field;
    int n_mismatch = 0;
    int tests_run = 0;

    uiaf_top dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_mode, .usb_flags,
        .bus_reset_flag, .detach_flag, .sof_received, .frame_number,
        .combined_usb_irq, .low_speed_token_select, .device_address_field,
        .block_irq);

    uiaf_usb_model usb (.clk, .flags(usb_flags), .bus_reset_flag,
        .detach_flag, .host_mode, .sof_received, .frame_number);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop();
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic fail(input string m);
        n_mismatch++;
        $display("MISMATCH %0t %s", $time, m);
    endtask

    task automatic chk32(input logic [31:0] g, e, input string m);
        tests_run++;
        if (g !== e) fail(m);
    endtask

    task automatic chk1(input logic g, e, input string m);
        @(negedge clk);
        tests_run++;
        if (g !== e) fail(m);
    endtask

    // address and data offered together; each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY,
                      input logic [3:0] st = 4'hF);
        logic ah, wh, b;
        logic [1:0] r;
        b = 1'b0;
        r = 2'h3;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50 && !b; n++) begin
            @(negedge clk);
            ah = (s_axi_awvalid && s_axi_awready) === 1'b1;
            wh = (s_axi_wvalid && s_axi_wready) === 1'b1;
            b = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
        if (!b) fail("write timeout");
        chk32({30'h0, r}, {30'h0, er}, "write response");
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er = RESP_OKAY);
        logic ah, b;
        logic [31:0] d;
        logic [1:0] r;
        b = 1'b0;
        d = '0;
        r = 2'h3;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50 && !b; n++) begin
            @(negedge clk);
            ah = (s_axi_arvalid && s_axi_arready) === 1'b1;
            b = s_axi_rvalid === 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (b) s_axi_rready <= 1'b0;
        end
        if (!b) fail("read timeout");
        chk32(d, e, "read data");
        chk32({30'h0, r}, {30'h0, er}, "read response");
    endtask

    initial begin
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(OFF_IRQ_ENABLE, 32'h0);
        rd_chk(OFF_DEV_ADDR, 32'h0);
        rd_chk(OFF_FRAME_LOW, 32'h0);
        wr(OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
        rd_chk(OFF_IRQ_ENABLE, 32'h0000_00FF);
        wr(OFF_DEV_ADDR, 32'hFFFF_FFA5);
        rd_chk(OFF_DEV_ADDR, 32'h0000_00A5);
        chk1(low_speed_token_select, 1'b1, "low speed set");
        chk32(32'(device_address_field), 32'h25, "address");
        wr(OFF_DEV_ADDR, 32'h0000_005A);
        chk1(low_speed_token_select, 1'b0, "full speed");
        chk32(32'(device_address_field), 32'h5A, "address");
        // one enable at a time against each of sources 1 to 7
        for (int i = 1; i < 8; i++) begin
            wr(OFF_IRQ_ENABLE, 32'(1 << i));
            for (int j = 1; j < 8; j++) begin
                usb.set_src(8'(1 << j), 1'b1, 1'b1, 1'b0);
                chk1(combined_usb_irq, i == j, "gating");
            end
        end
        // bit 0 follows the role: bus reset in device, detach in host
        wr(OFF_IRQ_ENABLE, 32'h1);
        for (int k = 0; k < 4; k++) begin
            usb.set_src(8'hFE, k == 0 || k == 3, k == 1 || k == 2, k[1]);
            chk1(combined_usb_irq, !k[0], "bit0 role");
        end
        wr(OFF_IRQ_ENABLE, 32'h0);
        usb.set_src(8'hFF, 1'b1, 1'b1, 1'b0);
        chk1(combined_usb_irq, 1'b0, "all masked");
        usb.sof(11'h7A5);
        rd_chk(OFF_FRAME_LOW, 32'h0000_00A5);
        wr(OFF_FRAME_LOW, 32'h0000_0012);
        rd_chk(OFF_FRAME_LOW, 32'h0000_00A5);
        usb.sof(11'h15A);
        rd_chk(OFF_FRAME_LOW, 32'h0000_005A);
        // event status: clear, raise by an address write, mask, clear
        rd_chk(OFF_EVT_STATUS, 32'h7);
        wr(OFF_EVT_CLEAR, 32'h7);
        rd_chk(OFF_EVT_STATUS, 32'h0);
        rd_chk(OFF_EVT_CLEAR, 32'h0);
        wr(OFF_EVT_ENABLE, 32'h2);
        chk1(block_irq, 1'b0, "event idle");
        wr(OFF_DEV_ADDR, 32'h11);
        chk1(block_irq, 1'b1, "event raised");
        rd_chk(OFF_EVT_STATUS, 32'h2);
        wr(OFF_EVT_ENABLE, 32'h0);
        chk1(block_irq, 1'b0, "event masked");
        wr(OFF_EVT_CLEAR, 32'h2);
        rd_chk(OFF_EVT_STATUS, 32'h0);
        wr(OFF_DEV_ADDR, 32'h33, RESP_OKAY, 4'hE);
        chk32(32'(device_address_field), 32'h11, "lane 0 off");
        wr(8'h40, 32'h1, RESP_SLVERR);
        rd_chk(8'h40, 32'h0, RESP_SLVERR);
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fail("watchdog");
        report_and_stop();
    end
endmodule // testbench

// >>> verification/uiaf_usb_model.sv
// uiaf_usb_model: usb engine stand-in driving flags and sof captures.
// assumes tasks are called just after a rising clk edge by the bench.
module uiaf_usb_model (
    // clock
    input wire logic clk,
    // engine side
    output uiaf_pkg::uiaf_src_s flags,
    output logic bus_reset_flag,
    output logic detach_flag,
    output logic host_mode,
    output logic sof_received,
    output logic [uiaf_pkg::FRAME_W-1:0] frame_number
);
    timeunit 1ns;
    timeprecision 1ps;
    import uiaf_pkg::*;

    initial begin
        flags = '0;
        bus_reset_flag = 1'b0;
        detach_flag = 1'b0;
        host_mode = 1'b0;
        sof_received = 1'b0;
        frame_number = '0;
    end

    task automatic set_src(input logic [7:0] f, input logic br, det, hm);
        @(posedge clk);
        flags <= f;
        bus_reset_flag <= br;
        detach_flag <= det;
        host_mode <= hm;
        @(posedge clk);
    endtask

    // frame number is only valid with the pulse; scrambled afterwards
    task automatic sof(input logic [FRAME_W-1:0] fr);
        @(posedge clk);
        sof_received <= 1'b1;
        frame_number <= fr;
        @(posedge clk);
        sof_received <= 1'b0;
        frame_number <= ~fr;
        @(posedge clk);
    endtask
endmodule // uiaf_usb_model
